// *** hw/rtcvr_pkg.sv ***
// package: constants and carrier types of the rtc and regulator wake block
package rtcvr_pkg;

   // ****************************************************
   // sizes
   // ****************************************************
   localparam int CNT_W  = 40;                // counter and match width
   localparam int NBYTES = 5;                 // bytes per 40-bit set

   // ****************************************************
   // configuration mux addresses
   // ****************************************************
   localparam logic [7:0] ADDR_CNT0  = 8'h40; // counter byte 0
   localparam logic [7:0] ADDR_MAT0  = 8'h48; // match byte 0
   localparam logic [7:0] ADDR_MBIT0 = 8'h50; // per-bit match flags byte 0
   localparam logic [7:0] ADDR_CTRL  = 8'h58; // control / status
   localparam logic [7:0] ADDR_TEST  = 8'h59; // test, reads zero here

   // ****************************************************
   // reset values and timing counts
   // ****************************************************
   localparam logic [7:0] CTRL_RESET   = 8'h00; // all bits clear
   localparam int         RST_STAGES   = 2;     // config clock edges
   localparam int         PS_DIV       = 128;   // prescaler divide
   localparam int         PS_FIRST     = 64;    // edges to first step
   localparam logic [6:0] PS_TICK_AT   = 7'(PS_FIRST - 1);
   localparam logic [1:0] XMODE_32K    = 2'b01; // mode for 32 kHz part
   localparam logic [1:0] VR_INIT_OFF  = 2'b00; // init code: stay off

   // ****************************************************
   // types
   // ****************************************************
   // control / status register, bit 7 down to bit 0
   typedef struct packed {
      logic       soft_rst;       // bit 7
      logic       cnt_en;         // bit 6
      logic       match_out_en;   // bit 5
      logic [1:0] xmode;          // bits 4:3
      logic       clr_on_match;   // bit 2
      logic       run;            // bit 1
      logic       xsel;           // bit 0
   } rtcvr_ctrl_t;

   // one configuration mux access
   typedef struct packed {
      logic       wen;            // write strobe
      logic       ren;            // read strobe
      logic [7:0] addr;           // byte address
      logic [7:0] wdata;          // write byte
   } rtcvr_acm_req_t;

   // oscillator enable and mode
   typedef struct packed {
      logic       en;             // oscillator enable
      logic [1:0] mode;           // oscillator mode
   } rtcvr_osc_t;

   // which 40-bit set the capture register holds
   typedef enum logic [2:0] {
      SEL_NONE  = 3'b001,
      SEL_CNT   = 3'b010,
      SEL_MATCH = 3'b100
   } rtcvr_sel_t;

endpackage

// *** hw/rtcvr_tk.sv ***
// prescaler and 40-bit real-time counter
`timescale 1ns/1ns
module rtcvr_tk
   import rtcvr_pkg::*;
(
   input  wire logic                i_clk,        // config clock
   input  wire logic                i_arst_n,     // async reset
   input  wire logic                i_tk_rst,     // timekeeping reset
   input  wire logic                i_run,        // counter run
   input  wire logic                i_cnt_en,     // count enable
   input  wire logic                i_clr_on_match, // clear on match
   input  wire logic                i_match_hit,  // counter equals match
   input  wire logic                i_xtal,       // crystal clock level
   input  wire logic [NBYTES-1:0]   i_wr_en,      // byte write strobes
   input  wire logic [7:0]          i_wr_data,    // byte to write
   output logic      [CNT_W-1:0]    o_count       // counter value
);
   import rtcvr_pkg::*;

   // ****************************************************
   // state
   // ****************************************************
   typedef struct packed {
      logic             xtal;     // crystal level, last cycle
      logic [6:0]       ps;       // prescaler
      logic [CNT_W-1:0] cnt;      // counter
   } rtcvr_tk_st_t;

   rtcvr_tk_st_t q;               // registered state
   rtcvr_tk_st_t d;               // next state
   logic         xedge;           // crystal rising edge
   logic         tick;            // prescaled clock rising edge

   assign xedge = i_xtal & ~q.xtal;
   assign tick  = xedge & (q.ps == PS_TICK_AT);

   // next state: writes, then step, then the run gate on top
   always_comb begin
      d      = q;
      d.xtal = i_xtal;
      if (i_tk_rst) begin
         d.ps  = '0;
         d.cnt = '0;
      end else begin
         for (int i = 0; i < NBYTES; i++) begin
            if (i_wr_en[i]) begin
               d.cnt[i*8 +: 8] = i_wr_data;
            end
         end
         // prescaler held clear while paused or stopped; the count is kept only while paused
         if (!i_cnt_en || !i_run) begin
            d.ps = '0;
         end else if (xedge) begin
            d.ps = q.ps + 7'h01;
            if (tick) begin
               // a match clears at the next prescaled edge
               if (i_clr_on_match && i_match_hit) begin
                  d.cnt = '0;
               end else begin
                  d.cnt = q.cnt + 40'h01;
               end
            end
         end
         if (!i_run) begin
            d.cnt = '0;
         end
      end
   end

   // state register
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_count = q.cnt;

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   property p_step;
      (!i_tk_rst && i_run && i_cnt_en && tick && !i_match_hit
       && i_wr_en == '0) |=> (o_count == $past(o_count) + 40'h01);
   endproperty
   a_step: assert property (p_step) else $error("counter missed a step");

   property p_pause;
      (!i_tk_rst && i_run && !i_cnt_en && i_wr_en == '0)
         |=> ($stable(o_count) && q.ps == 7'h00);
   endproperty
   a_pause: assert property (p_pause) else $error("pause lost count");

   property p_hold_zero;
      !i_run |=> (o_count == '0);
   endproperty
   a_hold_zero: assert property (p_hold_zero) else $error("run low, nonzero");

   property p_clear_match;
      (!i_tk_rst && i_run && i_cnt_en && tick && i_clr_on_match
       && i_match_hit) |=> (o_count == '0);
   endproperty
   a_clear_match: assert property (p_clear_match) else $error("no clear");

   c_clear: cover property (tick && i_clr_on_match && i_match_hit);

endmodule // rtcvr_tk

// *** hw/rtcvr_vr.sv ***
// regulator initialisation and enable latch
`timescale 1ns/1ns
module rtcvr_vr
   import rtcvr_pkg::*;
#(
   parameter logic [1:0] VR_INIT_BITS = VR_INIT_OFF // design-time code
)(
   input  wire logic i_clk,           // config clock
   input  wire logic i_arst_n,        // async reset
   input  wire logic i_supply_good,   // supply above good threshold
   input  wire logic i_wake_pin_n,    // wake pin, low requests power
   input  wire logic i_match,         // timer match
   input  wire logic i_fabric_vr_off, // fabric turns regulator off
   output logic      o_vr_enable      // regulator enable
);
   import rtcvr_pkg::*;

   // ****************************************************
   // state
   // ****************************************************
   typedef struct packed {
      logic init_done;            // init bits already read
      logic en;                   // regulator enable
   } rtcvr_vr_st_t;

   rtcvr_vr_st_t q;               // registered state
   rtcvr_vr_st_t d;               // next state
   logic         init_trig;       // init asks for power

   // init bits are read on the first good-supply cycle after reset or supply loss
   assign init_trig = i_supply_good & ~q.init_done
                      & (VR_INIT_BITS != VR_INIT_OFF);

   // any source sets; the fabric or supply loss clears, and a set wins over the fabric
   always_comb begin
      d = q;
      if (!i_supply_good) begin
         d = '0;
      end else begin
         d.init_done = 1'b1;
         if (!i_wake_pin_n || i_match || init_trig) begin
            d.en = 1'b1;
         end else if (i_fabric_vr_off) begin
            d.en = 1'b0;
         end
      end
   end

   // state register
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_vr_enable = q.en;

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   property p_vr_keep;
      (o_vr_enable && !i_fabric_vr_off && i_supply_good) |=> o_vr_enable;
   endproperty
   a_vr_keep: assert property (p_vr_keep) else $error("regulator dropped");

   property p_vr_wake;
      (i_supply_good && (!i_wake_pin_n || i_match)) |=> o_vr_enable;
   endproperty
   a_vr_wake: assert property (p_vr_wake) else $error("wake ignored");

   property p_vr_off;
      (!i_supply_good || (i_fabric_vr_off && i_wake_pin_n && !i_match
       && !init_trig)) |=> !o_vr_enable;
   endproperty
   a_vr_off: assert property (p_vr_off) else $error("regulator not off");

   c_vr_on: cover property ($rose(o_vr_enable));

endmodule // rtcvr_vr

// *** hw/rtcvr_top.sv ***
// rtc control/status, register access, match logic and regulator wake
`timescale 1ns/1ns

module rtcvr_top
   import rtcvr_pkg::*;
#(
   parameter logic [1:0] VR_INIT_BITS = VR_INIT_OFF // regulator init code
)(
   input  wire logic           i_clk,             // config mux clock
   input  wire logic           i_arst_n,          // async reset, low
   input  rtcvr_pkg::rtcvr_acm_req_t i_acm,       // mux access
   output logic [7:0]          o_acm_rdata,       // read byte
   input  wire logic           i_crystal_clock_in, // crystal clock level
   input  wire logic           i_supply_good,     // supply good detector
   input  wire logic           i_wake_pin_n,      // wake pin, low active
   input  wire logic           i_fabric_vr_off,   // fabric power-off
   input  rtcvr_pkg::rtcvr_osc_t i_fabric_osc,    // fabric oscillator ctl
   output logic                o_match_output,    // counter match
   output logic [1:0]          o_crystal_mode_outputs, // crystal mode
   output logic                o_crystal_select_output, // crystal select
   output rtcvr_pkg::rtcvr_osc_t o_osc,           // oscillator control
   output logic                o_vr_enable        // regulator enable
);
   import rtcvr_pkg::*;

   // ****************************************************
   // helpers
   // ****************************************************
   // byte i of a 40-bit word
   function automatic logic [7:0] byte_of(logic [CNT_W-1:0] v,
                                          logic [2:0] i);
      logic [7:0] b;
      b = 8'h00;
      for (int k = 0; k < NBYTES; k++) begin
         if (i == 3'(k)) begin
            b = v[k*8 +: 8];
         end
      end
      return b;
   endfunction

   // address falls in the five-byte set starting at base
   function automatic logic in_set(logic [7:0] a, logic [7:0] base);
      return (a >= base) && (a < base + 8'(NBYTES));
   endfunction

   // byte index of an address within its set
   function automatic logic [2:0] idx_of(logic [7:0] a,
                                         logic [7:0] base);
      logic [7:0] off;
      off = a - base;
      return off[2:0];
   endfunction

   // ****************************************************
   // state
   // ****************************************************
   typedef struct packed {
      rtcvr_ctrl_t      ctrl;     // control / status
      logic [1:0]       rst_sh;   // reset release shifter
      logic [CNT_W-1:0] mat;      // match register
      logic [CNT_W-1:0] cap;      // capture register
      rtcvr_sel_t       sel;      // set held in capture
      logic [7:0]       rdata;    // read data
      logic             match;    // match output
      logic [1:0]       xmode;    // crystal mode outputs
      logic             xsel;     // crystal select output
      rtcvr_osc_t       osc;      // effective oscillator control
   } rtcvr_top_st_t;

   rtcvr_top_st_t    q;           // registered state
   rtcvr_top_st_t    d;           // next state
   logic             tk_rst;      // timekeeping reset
   logic             rst_ok;      // release conditions hold
   logic [CNT_W-1:0] count;       // counter from timekeeping
   logic [CNT_W-1:0] mbits;       // per-bit equality flags
   logic             hit;         // all 40 bits equal
   logic [NBYTES-1:0] cnt_wr;     // counter byte writes
   logic [2:0]       a_idx_c;     // index within counter set
   logic [2:0]       a_idx_m;     // index within match set
   logic [2:0]       a_idx_b;     // index within match-flag set

   // ****************************************************
   // combinational decode
   // ****************************************************
   assign rst_ok  = i_supply_good & ~q.ctrl.soft_rst;
   // released only when both shifter stages are set
   assign tk_rst  = ~q.rst_sh[1];
   assign mbits   = ~(count ^ q.mat);
   assign hit     = &mbits;
   assign a_idx_c = idx_of(i_acm.addr, ADDR_CNT0);
   assign a_idx_m = idx_of(i_acm.addr, ADDR_MAT0);
   assign a_idx_b = idx_of(i_acm.addr, ADDR_MBIT0);

   // counter byte writes go straight into the timekeeping block;
   // counting must be disabled first or a step may race the write
   always_comb begin
      cnt_wr = '0;
      if (i_acm.wen && in_set(i_acm.addr, ADDR_CNT0) && !tk_rst) begin
         cnt_wr[a_idx_c] = 1'b1;
      end
   end

   // ****************************************************
   // next state
   // ****************************************************
   always_comb begin
      d = q;

      // control writes land on the clock edge
      if (i_acm.wen && i_acm.addr == ADDR_CTRL) begin
         d.ctrl = rtcvr_ctrl_t'(i_acm.wdata);
      end
      // supply loss overrides any write
      if (!i_supply_good) begin
         d.ctrl = rtcvr_ctrl_t'(CTRL_RESET);
      end

      // two-edge synchronous release
      if (!rst_ok) begin
         d.rst_sh = 2'b00;
      end else begin
         d.rst_sh = {q.rst_sh[0], 1'b1};
      end

      // match register writes
      if (i_acm.wen && in_set(i_acm.addr, ADDR_MAT0)) begin
         d.mat[a_idx_m*8 +: 8] = i_acm.wdata;
      end

      // reads: byte 0 of the counter or match set captures the whole set
      if (i_acm.ren) begin
         d.rdata = 8'h00; // unmapped reads give zero
         if (in_set(i_acm.addr, ADDR_CNT0)) begin
            if (a_idx_c == 3'd0) begin
               d.cap   = count;
               d.sel   = SEL_CNT;
               d.rdata = count[7:0];
            end else begin
               d.rdata = byte_of(q.cap, a_idx_c);
            end
         end else if (in_set(i_acm.addr, ADDR_MAT0)) begin
            if (a_idx_m == 3'd0) begin
               d.cap   = q.mat;
               d.sel   = SEL_MATCH;
               d.rdata = q.mat[7:0];
            end else begin
               d.rdata = byte_of(q.cap, a_idx_m);
            end
         end else if (in_set(i_acm.addr, ADDR_MBIT0)) begin
            d.rdata = byte_of(mbits, a_idx_b);
         end else if (i_acm.addr == ADDR_CTRL) begin
            d.rdata = q.ctrl;
         end
      end

      // timekeeping reset also clears match and capture
      if (tk_rst) begin
         d.mat = '0;
         d.cap = '0;
         d.sel = SEL_NONE;
      end

      // match output gated by its enable
      d.match = q.ctrl.match_out_en & hit & ~tk_rst;

      // crystal outputs follow the control bits
      d.xmode = q.ctrl.xmode;
      d.xsel  = q.ctrl.xsel;

      // owner of the oscillator: block when select set, else fabric
      if (q.ctrl.xsel) begin
         d.osc.en   = 1'b1;
         d.osc.mode = q.ctrl.xmode;
      end else begin
         d.osc = i_fabric_osc;
      end
   end

   // ****************************************************
   // state register
   // ****************************************************
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         q      <= '0;
         q.ctrl <= rtcvr_ctrl_t'(CTRL_RESET);
         q.sel  <= SEL_NONE;
      end else begin
         q <= d;
      end
   end

   // ****************************************************
   // submodules
   // ****************************************************
   // prescaler and counter
   rtcvr_tk u_tk (
      .i_clk          (i_clk),
      .i_arst_n       (i_arst_n),
      .i_tk_rst       (tk_rst),
      .i_run          (q.ctrl.run),
      .i_cnt_en       (q.ctrl.cnt_en),
      .i_clr_on_match (q.ctrl.clr_on_match),
      .i_match_hit    (hit),
      .i_xtal         (i_crystal_clock_in),
      .i_wr_en        (cnt_wr),
      .i_wr_data      (i_acm.wdata),
      .o_count        (count)
   );

   // regulator wake logic takes the gated match output
   rtcvr_vr #(
      .VR_INIT_BITS (VR_INIT_BITS)
   ) u_vr (
      .i_clk           (i_clk),
      .i_arst_n        (i_arst_n),
      .i_supply_good   (i_supply_good),
      .i_wake_pin_n    (i_wake_pin_n),
      .i_match         (q.match),
      .i_fabric_vr_off (i_fabric_vr_off),
      .o_vr_enable     (o_vr_enable)
   );

   // ****************************************************
   // outputs, all from flip-flops
   // ****************************************************
   assign o_acm_rdata             = q.rdata;
   assign o_match_output          = q.match;
   assign o_crystal_mode_outputs  = q.xmode;
   assign o_crystal_select_output = q.xsel;
   assign o_osc                   = q.osc;

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   property p_soft_rst;
      q.ctrl.soft_rst |=> tk_rst;
   endproperty
   a_soft_rst: assert property (p_soft_rst) else $error("soft reset lost");

   property p_release;
      $fell(tk_rst) |-> ($past(rst_ok, 1) && $past(rst_ok, 2));
   endproperty
   a_release: assert property (p_release) else $error("early release");

   property p_release_time;
      (!rst_ok ##1 rst_ok [*2]) |=> !tk_rst;
   endproperty
   a_release_time: assert property (p_release_time) else $error("late release");

   property p_ctrl_clear;
      !i_supply_good |=> (q.ctrl == rtcvr_ctrl_t'(CTRL_RESET));
   endproperty
   a_ctrl_clear: assert property (p_ctrl_clear) else $error("ctrl not clear");

   property p_match;
      ##1 (o_match_output ==
           $past(q.ctrl.match_out_en && count == q.mat && !tk_rst));
   endproperty
   a_match: assert property (p_match) else $error("match output wrong");

   property p_xmode;
      ##1 (o_crystal_mode_outputs == $past(q.ctrl.xmode)
           && o_crystal_select_output == $past(q.ctrl.xsel));
   endproperty
   a_xmode: assert property (p_xmode) else $error("crystal pins wrong");

   property p_osc_own;
      q.ctrl.xsel |=> (o_osc.mode == $past(q.ctrl.xmode) && o_osc.en);
   endproperty
   a_osc_own: assert property (p_osc_own) else $error("oscillator owner");

   property p_capture;
      (i_acm.ren && i_acm.addr == ADDR_CNT0 && !tk_rst)
         |=> (q.cap == $past(count) && o_acm_rdata == $past(count[7:0]));
   endproperty
   a_capture: assert property (p_capture) else $error("capture failed");

   property p_ctrl_read;
      (i_acm.ren && i_acm.addr == ADDR_CTRL) |=> (o_acm_rdata == $past(q.ctrl));
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("status read");

   c_match_rise: cover property ($rose(o_match_output));
   c_capture:    cover property (i_acm.ren && i_acm.addr == ADDR_CNT0
                                 ##1 i_acm.ren && i_acm.addr == 8'h44);
   c_release:    cover property ($fell(tk_rst));

endmodule // rtcvr_top

// *** testbench/rtcvr_fab.sv ***
// fabric-side model: config mux accesses and the crystal clock
`timescale 1ns/1ns
module rtcvr_fab (
   input  wire logic                 i_clk, // config clock
   output rtcvr_pkg::rtcvr_acm_req_t o_acm, // mux access
   output logic                      o_xtal // crystal level
);
   import rtcvr_pkg::*;
   logic [1:0] div_q; // crystal runs at a quarter of the config rate
   initial begin
      o_acm = '0;
      div_q = 2'h0;
   end
   // the oscillator runs free, and stays slower than half the config clock
   always @(negedge i_clk) begin
      div_q <= div_q + 2'h1;
   end
   assign o_xtal = div_q[1];
   // one access across one taking edge; released fields show inverted data
   task automatic acc(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] d);
      @(negedge i_clk);
      o_acm = '{wen: w, ren: r, addr: a, wdata: d};
      @(negedge i_clk);
      o_acm = '{wen: 1'b0, ren: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule // rtcvr_fab

// *** testbench/rtc_control_and_vr_wakeup_bench.sv ***
// self-checking bench for the rtc control and regulator wake block
`timescale 1ns/1ns
module rtc_control_and_vr_wakeup_bench;
   import rtcvr_pkg::*;
   logic           clk, arst_n, sup, wake_n, off, mo, xs, vr, xtal, vri;
   logic [1:0]     xm;
   logic [7:0]     rd;
   rtcvr_acm_req_t acm;
   rtcvr_osc_t     fosc, osc;
   int             mismatches, comparisons;
   always #25 clk = ~clk;
   rtcvr_fab fab (.i_clk(clk), .o_acm(acm), .o_xtal(xtal));
   rtcvr_top dut (.i_clk(clk), .i_arst_n(arst_n), .i_acm(acm),
      .o_acm_rdata(rd), .i_crystal_clock_in(xtal), .i_supply_good(sup),
      .i_wake_pin_n(wake_n), .i_fabric_vr_off(off), .i_fabric_osc(fosc),
      .o_match_output(mo), .o_crystal_mode_outputs(xm),
      .o_crystal_select_output(xs), .o_osc(osc), .o_vr_enable(vr));
   // second copy built with a power-up init code, to see the init path
   rtcvr_top #(.VR_INIT_BITS(2'b01)) dut_init (.i_clk(clk),
      .i_arst_n(arst_n), .i_acm(acm), .o_acm_rdata(),
      .i_crystal_clock_in(xtal), .i_supply_good(sup),
      .i_wake_pin_n(wake_n), .i_fabric_vr_off(off), .i_fabric_osc(fosc),
      .o_match_output(), .o_crystal_mode_outputs(),
      .o_crystal_select_output(), .o_osc(), .o_vr_enable(vri));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      fab.acc(1'b0, 1'b1, a, 8'h00);
      chk(rd, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      fab.acc(1'b1, 1'b0, a, d);
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic complete_run();
      if (mismatches == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // mode and select follow the control bits; select hands over the osc
   task automatic t_ctrl();
      wr(ADDR_CTRL, 8'h09);
      rdc(ADDR_CTRL, 8'h09);
      wt(1);
      chk({5'h0, xm, xs}, 8'h03);
      chk({5'h0, osc}, 8'h05);
      fosc = '{en: 1'b1, mode: 2'b11};
      wr(ADDR_CTRL, 8'h10);
      wt(1);
      chk({5'h0, xm, xs}, 8'h04);
      chk({5'h0, osc}, 8'h07);
   endtask
   // first step at the 64th crystal edge, then match and regulator wake
   task automatic t_count();
      wr(ADDR_MAT0, 8'h01);
      wr(ADDR_CTRL, 8'h62);
      wt(200);
      chk({7'h0, mo}, 8'h00);
      wt(80);
      rdc(ADDR_CNT0, 8'h01);
      chk({7'h0, mo}, 8'h01);
      chk({7'h0, vr}, 8'h01);
   endtask
   // fabric turns the regulator off; the wake pin turns it on
   task automatic t_vr();
      wr(ADDR_CTRL, 8'h02);
      off = 1'b1;
      wt(3);
      chk({7'h0, vr}, 8'h00);
      chk({7'h0, mo}, 8'h00);
      off = 1'b0;
      wake_n = 1'b0;
      wt(2);
      wake_n = 1'b1;
      wt(3);
      chk({7'h0, vr}, 8'h01);
   endtask
   // soft reset clears the count; supply loss clears control and regulator
   task automatic t_rst();
      wr(ADDR_CTRL, 8'h82);
      // the soft reset reaches the counter two edges after the write
      wt(1);
      rdc(ADDR_CNT0, 8'h00);
      rdc(ADDR_CTRL, 8'h82);
      sup = 1'b0;
      wt(2);
      rdc(ADDR_CTRL, 8'h00);
      chk({7'h0, vr}, 8'h00);
      sup = 1'b1;
   endtask
   // preset count equal to match; with clear set the first step zeroes it
   task automatic t_clr();
      wr(ADDR_CTRL, 8'h02);
      wr(8'h40, 8'h05);
      wr(8'h41, 8'h3c);
      wr(ADDR_MAT0, 8'h05);
      wr(8'h49, 8'h3c);
      rdc(ADDR_CNT0, 8'h05);
      rdc(8'h41, 8'h3c);
      wr(ADDR_CTRL, 8'h46);
      wt(280);
      rdc(ADDR_CNT0, 8'h00);
      rdc(8'h41, 8'h00);
      rdc(ADDR_MBIT0, 8'hfa);
   endtask
   // watchdog: the tests need well under two thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      complete_run();
   end
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      sup = 1'b1;
      wake_n = 1'b1;
      off = 1'b0;
      fosc = '0;
      mismatches = 0;
      comparisons = 0;
      wt(10);
      arst_n = 1'b1;
      wt(4);
      chk({7'h0, vr}, 8'h00);
      chk({7'h0, vri}, 8'h01);
      t_ctrl();
      t_count();
      t_vr();
      t_rst();
      t_clr();
      complete_run();
   end
endmodule // rtc_control_and_vr_wakeup_bench
